// file: core/sps_pkg.sv
// sps_pkg: constants of the sdram pin function select block
// assumes an axi4-lite master on a 50 MHz aclk
// Behaviour
// - pins stay port i/o until written
// - port a 4-7 register: four 3-bit fields
// - pa7 code 010 drives area-3 select
// - pa9 code 101 drives clock enable
// - pa8 code 101 drives read/write direction
// - pa15 code 001 drives bus clock
// - pa13 code 001 drives upper byte mask
// - pa12 code 001 drives lower byte mask
// - pb5 code 100 drives column strobe
// - pb4 code 100 drives row strobe
// - port c 0-3 register: one bit each
// - pc0-3 bit set drives address A0-A3
package sps_pkg;
  localparam int SPS_ADDR_W = 8;
  localparam int SPS_PINS = 20;
  localparam int SPS_NREG = 5;
  // register byte offsets
  localparam logic [7:0] SPS_OFS_PA_4_7 = 8'h00;
  localparam logic [7:0] SPS_OFS_PA_8_11 = 8'h04;
  localparam logic [7:0] SPS_OFS_PA_12_15 = 8'h08;
  localparam logic [7:0] SPS_OFS_PB_4_7 = 8'h0C;
  localparam logic [7:0] SPS_OFS_PC_0_3 = 8'h10;
  localparam logic [7:0] SPS_OFS_STATUS = 8'h14;
  // field layout
  localparam int SPS_FLD0 = 0;
  localparam int SPS_FLD1 = 4;
  localparam int SPS_FLD2 = 8;
  localparam int SPS_FLD3 = 12;
  localparam int SPS_SEL_W = 3;
  localparam logic [15:0] SPS_MASK_WIDE = 16'h7777;
  localparam logic [15:0] SPS_MASK_NARROW = 16'h1111;
  localparam logic [15:0] SPS_RST_CTRL = 16'h0000;
  // selector codes
  localparam logic [2:0] SPS_SEL_PORT_IO = 3'h0;
  localparam logic [2:0] SPS_SEL_CHIP = 3'h2;
  localparam logic [2:0] SPS_SEL_CKE = 3'h5;
  localparam logic [2:0] SPS_SEL_DIR = 3'h5;
  localparam logic [2:0] SPS_SEL_CLK = 3'h1;
  localparam logic [2:0] SPS_SEL_MASK = 3'h1;
  localparam logic [2:0] SPS_SEL_STROBE = 3'h4;
  localparam logic SPS_SEL_ADDR = 1'h1;
  // axi responses
  localparam logic [1:0] SPS_RESP_OKAY = 2'h0;
  localparam logic [1:0] SPS_RESP_SLVERR = 2'h2;
  // pin positions in the pin vectors
  localparam int SPS_PIN_PA7 = 3;
  localparam int SPS_PIN_PA8 = 4;
  localparam int SPS_PIN_PA9 = 5;
  localparam int SPS_PIN_PA12 = 8;
  localparam int SPS_PIN_PA13 = 9;
  localparam int SPS_PIN_PA15 = 11;
  localparam int SPS_PIN_PB4 = 12;
  localparam int SPS_PIN_PB5 = 13;
endpackage : sps_pkg

// file: core/sps_top.sv
// sps_top: register file and pin multiplexer for sdram pins
// assumes an axi4-lite master, synchronous port and bus signals
`timescale 1ns/10ps
module sps_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // general port i/o side
  input wire logic [19:0] port_out,
  input wire logic [19:0] port_oe,
  // memory bus controller side
  input wire logic chip_select_area3_n,
  input wire logic clock_enable,
  input wire logic read_write_direction,
  input wire logic bus_clock,
  input wire logic upper_byte_mask,
  input wire logic lower_byte_mask,
  input wire logic column_strobe_out_n,
  input wire logic row_strobe_out_n,
  input wire logic [3:0] mem_addr,
  // pads
  output logic [19:0] pin_out,
  output logic [19:0] pin_oe
);

  localparam logic [7:0] OFS_TAB [sps_pkg::SPS_NREG] = '{
    sps_pkg::SPS_OFS_PA_4_7, sps_pkg::SPS_OFS_PA_8_11,
    sps_pkg::SPS_OFS_PA_12_15, sps_pkg::SPS_OFS_PB_4_7,
    sps_pkg::SPS_OFS_PC_0_3};
  localparam logic [15:0] MASK_TAB [sps_pkg::SPS_NREG] = '{
    sps_pkg::SPS_MASK_WIDE, sps_pkg::SPS_MASK_WIDE,
    sps_pkg::SPS_MASK_WIDE, sps_pkg::SPS_MASK_WIDE,
    sps_pkg::SPS_MASK_NARROW};

  logic aw_hold_reg;
  logic [7:0] aw_addr_reg;
  logic w_hold_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [19:0] pin_out_reg;
  logic [19:0] pin_oe_reg;
  logic [15:0] ctrl_q [sps_pkg::SPS_NREG];
  logic [sps_pkg::SPS_NREG-1:0] wr_hit;
  logic [sps_pkg::SPS_NREG-1:0] rd_hit;
  logic [15:0] rd_ctrl;
  logic [19:0] mem_sel;
  logic [19:0] mem_sig;

  // handshake and write decode
  wire aw_take = awvalid & awready;
  wire w_take = wvalid & wready;
  wire ar_take = arvalid & arready;
  wire wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  wire wr_status = aw_addr_reg[7:2] == sps_pkg::SPS_OFS_STATUS[7:2];
  wire wr_ok = (|wr_hit) | wr_status;
  wire rd_status = araddr[7:2] == sps_pkg::SPS_OFS_STATUS[7:2];
  wire rd_ok = (|rd_hit) | rd_status;
  assign awready = ~aw_hold_reg;
  assign wready = ~w_hold_reg;
  assign arready = ~rvalid_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // control registers, one per generate entry
  genvar k;
  generate
    for (k = 0; k < sps_pkg::SPS_NREG; k++) begin : g_reg
      logic [15:0] val_reg;
      logic [15:0] val_next;
      assign wr_hit[k] = aw_addr_reg[7:2] == OFS_TAB[k][7:2];
      assign rd_hit[k] = araddr[7:2] == OFS_TAB[k][7:2];
      assign val_next = {w_strb_reg[1] ? w_data_reg[15:8] : val_reg[15:8],
                         w_strb_reg[0] ? w_data_reg[7:0] : val_reg[7:0]} & MASK_TAB[k];
      assign ctrl_q[k] = val_reg;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          val_reg <= sps_pkg::SPS_RST_CTRL;
        end else if (wr_fire && wr_hit[k]) begin
          val_reg <= val_next;
        end
      end
    end
  endgenerate

  // write address and data holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (aw_take) begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= awaddr;
    end else if (wr_fire) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (w_take) begin
      w_hold_reg <= 1'b1;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end else if (wr_fire) begin
      w_hold_reg <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= sps_pkg::SPS_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_ok ? sps_pkg::SPS_RESP_OKAY : sps_pkg::SPS_RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // read select over the control registers
  always_comb begin
    rd_ctrl = 16'h0000;
    for (int i = 0; i < sps_pkg::SPS_NREG; i++) begin
      if (rd_hit[i]) begin
        rd_ctrl = ctrl_q[i];
      end
    end
  end

  // read data; upper bits zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= sps_pkg::SPS_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_status ? {12'h000, mem_sel} : {16'h0000, rd_ctrl};
      rresp_reg <= rd_ok ? sps_pkg::SPS_RESP_OKAY : sps_pkg::SPS_RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  wire [2:0] pa_pin7_selector = ctrl_q[0][sps_pkg::SPS_FLD3 +: sps_pkg::SPS_SEL_W];
  wire [2:0] pa_pin9_selector = ctrl_q[1][sps_pkg::SPS_FLD1 +: sps_pkg::SPS_SEL_W];
  wire [2:0] pa_pin8_selector = ctrl_q[1][sps_pkg::SPS_FLD0 +: sps_pkg::SPS_SEL_W];
  wire [2:0] pa_pin15_selector = ctrl_q[2][sps_pkg::SPS_FLD3 +: sps_pkg::SPS_SEL_W];
  wire [2:0] pa_pin13_selector = ctrl_q[2][sps_pkg::SPS_FLD1 +: sps_pkg::SPS_SEL_W];
  wire [2:0] pa_pin12_selector = ctrl_q[2][sps_pkg::SPS_FLD0 +: sps_pkg::SPS_SEL_W];
  wire [2:0] pb_pin5_selector = ctrl_q[3][sps_pkg::SPS_FLD1 +: sps_pkg::SPS_SEL_W];
  wire [2:0] pb_pin4_selector = ctrl_q[3][sps_pkg::SPS_FLD0 +: sps_pkg::SPS_SEL_W];
  wire pc_pin0_select_bit = ctrl_q[4][sps_pkg::SPS_FLD0];
  wire pc_pin1_select_bit = ctrl_q[4][sps_pkg::SPS_FLD1];
  wire pc_pin2_select_bit = ctrl_q[4][sps_pkg::SPS_FLD2];
  wire pc_pin3_select_bit = ctrl_q[4][sps_pkg::SPS_FLD3];

  wire sel_pa7 = pa_pin7_selector == sps_pkg::SPS_SEL_CHIP;
  wire sel_pa9 = pa_pin9_selector == sps_pkg::SPS_SEL_CKE;
  wire sel_pa8 = pa_pin8_selector == sps_pkg::SPS_SEL_DIR;
  wire sel_pa15 = pa_pin15_selector == sps_pkg::SPS_SEL_CLK;
  wire sel_pa13 = pa_pin13_selector == sps_pkg::SPS_SEL_MASK;
  wire sel_pa12 = pa_pin12_selector == sps_pkg::SPS_SEL_MASK;
  wire sel_pb5 = pb_pin5_selector == sps_pkg::SPS_SEL_STROBE;
  wire sel_pb4 = pb_pin4_selector == sps_pkg::SPS_SEL_STROBE;
  wire [3:0] sel_pc = {pc_pin3_select_bit, pc_pin2_select_bit,
                       pc_pin1_select_bit, pc_pin0_select_bit} & {4{sps_pkg::SPS_SEL_ADDR}};

  // pins without a memory function stay port i/o
  assign mem_sel = {sel_pc, 2'b00, sel_pb5, sel_pb4, sel_pa15, 1'b0, sel_pa13,
                    sel_pa12, 2'b00, sel_pa9, sel_pa8, sel_pa7, 3'b000};
  assign mem_sig = {mem_addr, 2'b00, column_strobe_out_n, row_strobe_out_n, bus_clock,
                    1'b0, upper_byte_mask, lower_byte_mask, 2'b00, clock_enable,
                    read_write_direction, chip_select_area3_n, 3'b000};

  // pad mux: memory signals are always driven outputs
  wire [19:0] pin_out_next = (mem_sel & mem_sig) | (~mem_sel & port_out);
  wire [19:0] pin_oe_next = mem_sel | port_oe;
  assign pin_out = pin_out_reg;
  assign pin_oe = pin_oe_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_reg <= 20'h00000;
      pin_oe_reg <= 20'h00000;
    end else begin
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  // checks on register contents and pad routing
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  port_io_keep_a: assert property (
    aresetn && mem_sel == 20'h00000 |=> pin_out == $past(port_out) && pin_oe == $past(port_oe))
    else $error("port i/o not kept");
  pa_resv_zero_a: assert property (
    (ctrl_q[0] & ~sps_pkg::SPS_MASK_WIDE) == 16'h0000)
    else $error("port a reserved bit set");
  cs_route_a: assert property (
    sel_pa7 |=> pin_out[sps_pkg::SPS_PIN_PA7] == $past(chip_select_area3_n)
      && pin_oe[sps_pkg::SPS_PIN_PA7])
    else $error("area-3 select not routed");
  pa_low_port_a: assert property (
    aresetn |=> pin_out[2:0] == $past(port_out[2:0]))
    else $error("pa4-pa6 left port i/o");
  cke_route_a: assert property (
    sel_pa9 |=> pin_out[sps_pkg::SPS_PIN_PA9] == $past(clock_enable))
    else $error("clock enable not routed");
  dir_route_a: assert property (
    sel_pa8 |=> pin_out[sps_pkg::SPS_PIN_PA8] == $past(read_write_direction))
    else $error("direction not routed");
  clk_route_a: assert property (
    sel_pa15 |=> pin_out[sps_pkg::SPS_PIN_PA15] == $past(bus_clock))
    else $error("bus clock not routed");
  umask_route_a: assert property (
    sel_pa13 |=> pin_out[sps_pkg::SPS_PIN_PA13] == $past(upper_byte_mask))
    else $error("upper mask not routed");
  lmask_route_a: assert property (
    sel_pa12 |=> pin_out[sps_pkg::SPS_PIN_PA12] == $past(lower_byte_mask))
    else $error("lower mask not routed");
  cas_route_a: assert property (
    sel_pb5 |=> pin_out[sps_pkg::SPS_PIN_PB5] == $past(column_strobe_out_n))
    else $error("column strobe not routed");
  ras_route_a: assert property (
    sel_pb4 |=> pin_out[sps_pkg::SPS_PIN_PB4] == $past(row_strobe_out_n))
    else $error("row strobe not routed");
  pc_resv_zero_a: assert property (
    (ctrl_q[4] & ~sps_pkg::SPS_MASK_NARROW) == 16'h0000)
    else $error("port c reserved bit set");
  addr_route_a: assert property (
    ##1 (pin_out[19:16] & $past(sel_pc)) == ($past(mem_addr) & $past(sel_pc)))
    else $error("address bit not routed");
  rd_resv_zero_a: assert property (
    rvalid |-> rdata[31:20] == 12'h000)
    else $error("reserved read bits set");
  resp_hold_a: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  rst_port_io_a: assert property (
    $rose(aresetn) |-> mem_sel == 20'h00000)
    else $error("pin left selected after reset");
  mem_drive_a: assert property (
    aresetn |=> (pin_oe & $past(mem_sel)) == $past(mem_sel))
    else $error("memory pin not driven");

  wr_done_c: cover property (wr_fire ##[1:4] bvalid && bready);
  rd_done_c: cover property (ar_take ##[1:4] rvalid && rready);
  cs_on_c: cover property (sel_pa7 && sel_pb4 && sel_pb5);
  addr_on_c: cover property (sel_pc == 4'hF);

endmodule : sps_top

// file: testbench/sps_sdram_model.sv
// sps_sdram_model: the x16 memory as it sees the selected pads
// assumes pads sampled on aclk; the memory inputs have no pulls
`timescale 1ns/10ps
module sps_sdram_model (
  // clock
  input wire logic aclk,
  // pads from the selector block
  input wire logic [19:0] pin_out,
  input wire logic [19:0] pin_oe,
  // memory-side view: 0 select, 1 dir, 2 cke, 3-4 masks, 5 clock, 6-7 strobes, 11:8 address
  output logic [11:0] seen,
  output logic all_driven
);
  logic [11:0] val;
  logic [11:0] drv;
  // pick the memory pins out of the pad vectors
  assign val = {pin_out[19:16], pin_out[13:12], pin_out[11], pin_out[9:8], pin_out[5:3]};
  assign drv = {pin_oe[19:16], pin_oe[13:12], pin_oe[11], pin_oe[9:8], pin_oe[5:3]};
  // a floating input wanders: it reads the inverse of what it last held
  always_ff @(posedge aclk) begin
    seen <= (val & drv) | (~seen & ~drv);
    all_driven <= &drv;
  end
endmodule : sps_sdram_model

// file: testbench/sps_top_tb.sv
// sps_top_tb: register and pad checks of the sdram pin selector
// assumes sps_pkg, sps_top and sps_sdram_model are compiled first
`timescale 1ns/10ps
module sps_top_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, all_driven;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [19:0] port_out, port_oe, pin_out, pin_oe, on;
  logic [11:0] m_drv, seen;
  logic [2:0] c3;
  int n_errors, cmp_count;

  // clock, 20 ns period
  initial aclk = 1'b0;
  always #10 aclk = ~aclk;

  sps_top i_sps_top (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .port_out, .port_oe, .chip_select_area3_n(m_drv[0]), .read_write_direction(m_drv[1]),
    .clock_enable(m_drv[2]), .lower_byte_mask(m_drv[3]), .upper_byte_mask(m_drv[4]),
    .bus_clock(m_drv[5]), .row_strobe_out_n(m_drv[6]), .column_strobe_out_n(m_drv[7]),
    .mem_addr(m_drv[11:8]), .pin_out, .pin_oe);
  sps_sdram_model i_sps_sdram_model (.aclk, .pin_out, .pin_oe, .seen, .all_driven);

  // verdict and end of run
  task automatic final_report();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic hang();
    n_errors++;
    $display("MISMATCH %0t bus answer never came", $time);
    final_report();
  endtask : hang

  // axi4-lite write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    if (bvalid !== 1'b1) hang();
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic wrt(input logic [7:0] a, input logic [15:0] d);
    logic [1:0] r;
    wr(a, d, 4'hF, r);
  endtask : wrt

  // axi4-lite read
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    if (rvalid !== 1'b1) hang();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rdr

  // memory signals placed at their pad positions
  function automatic logic [19:0] mem_pins(input logic [11:0] m);
    return {m[11:8], 2'b00, m[7:6], m[5], 1'b0, m[4:3], 2'b00, m[2:0], 3'b000};
  endfunction : mem_pins

  // two opposite patterns: pads on carry memory signals, the rest port i/o
  task automatic pins(input logic [19:0] on_pins, input logic [11:0] m);
    logic [19:0] p;
    logic [19:0] q;
    logic [11:0] mm;
    for (int k = 0; k < 2; k++) begin
      p = k ? 20'hA5C3F : 20'h5A3C0;
      q = k ? 20'h0F0F0 : 20'hF0F0F;
      mm = k ? ~m : m;
      @(posedge aclk);
      port_out <= p;
      port_oe <= q;
      m_drv <= mm;
      repeat (3) @(posedge aclk);
      #1;
      chk({12'h000, pin_out}, {12'h000, (p & ~on_pins) | (mem_pins(mm) & on_pins)}, "pad value");
      chk({12'h000, pin_oe}, {12'h000, q | on_pins}, "pad enable");
    end
    rdr(sps_pkg::SPS_OFS_STATUS, rd, resp);
    chk(rd, {12'h000, on_pins}, "status");
  endtask : pins

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {port_out, port_oe, m_drv} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // after reset every pin is port i/o
    for (int i = 0; i < 5; i++) begin
      rdr(8'(4 * i), rd, resp);
      chk(rd, 32'h0, "reset value");
    end
    pins(20'h00000, 12'hA53);
    // reserved bits written as one read back zero
    for (int i = 0; i < 5; i++) begin
      wrt(8'(4 * i), 16'hFFFF);
      rdr(8'(4 * i), rd, resp);
      chk(rd, (i == 4) ? 32'h1111 : 32'h7777, "field mask");
    end
    pins(20'hF0000, 12'h3C6);
    // low byte lane alone
    wrt(sps_pkg::SPS_OFS_PB_4_7, 16'h0000);
    wr(sps_pkg::SPS_OFS_PB_4_7, 16'h4444, 4'h1, resp);
    rdr(sps_pkg::SPS_OFS_PB_4_7, rd, resp);
    chk(rd, 32'h0044, "lane write");
    // unmapped place is refused
    wr(8'h18, 16'hFFFF, 4'hF, resp);
    chk({30'h0, resp}, {30'h0, sps_pkg::SPS_RESP_SLVERR}, "unmapped write");
    rdr(8'h18, rd, resp);
    chk({30'h0, resp}, {30'h0, sps_pkg::SPS_RESP_SLVERR}, "unmapped read");
    chk(rd, 32'h0, "unmapped data");
    // bring-up: pins set first, then the memory sees every line driven
    wrt(sps_pkg::SPS_OFS_PA_4_7, 16'h2000);
    wrt(sps_pkg::SPS_OFS_PA_8_11, 16'h0055);
    wrt(sps_pkg::SPS_OFS_PA_12_15, 16'h1011);
    wrt(sps_pkg::SPS_OFS_PB_4_7, 16'h0044);
    wrt(sps_pkg::SPS_OFS_PC_0_3, 16'h1111);
    pins(mem_pins(12'hFFF), 12'h5A6);
    chk({20'h0, seen}, {20'h0, 12'hA59}, "memory view");
    chk({31'h0, all_driven}, 32'h1, "memory driven");
    // every code on every selector; only the documented code selects memory
    for (int c = 0; c < 8; c++) begin
      c3 = 3'(c);
      on = c3[0] ? 20'h50000 : 20'hA0000;
      if (c3 == 3'h2) on[3] = 1'b1;
      if (c3 == 3'h5) on[5:4] = 2'b11;
      if (c3 == 3'h1) on = on | 20'h00B00;
      if (c3 == 3'h4) on[13:12] = 2'b11;
      for (int i = 0; i < 4; i++) wrt(8'(4 * i), {4{1'b0, c3}});
      wrt(sps_pkg::SPS_OFS_PC_0_3, c3[0] ? 16'h0101 : 16'h1010);
      pins(on, 12'h3C5 ^ {9'h0, c3});
    end
    // a second reset in mid-run puts every pin back to port i/o
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(sps_pkg::SPS_OFS_PC_0_3, rd, resp);
    chk(rd, 32'h0, "second reset");
    pins(20'h00000, 12'h35A);
    final_report();
  end
endmodule : sps_top_tb
